/* rtl/psc_defines.svh */
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
// channel count codes
`define PSC_CHAN_TWELVE 2'h0
`define PSC_CHAN_BOOST 2'h3
// shunt codes and values in milliohm
`define PSC_SHUNT_MOHM_0 16'h01f4
`define PSC_SHUNT_MOHM_1 16'h03e8
`define PSC_SHUNT_MOHM_2 16'h05dc
`define PSC_SHUNT_MOHM_3 16'h07d0
// current scale factor per code (relative to 2 ohm = 1)
`define PSC_SCALE_0 3'h4
`define PSC_SCALE_1 3'h2
`define PSC_SCALE_2 3'h1
`define PSC_SCALE_3 3'h1
`define PSC_TEST_FUNC 2'h0
// mode change window after reset release
`define PSC_MODE_WIN_MS 100
`define PSC_CLK_MHZ 250
`define PSC_MODE_WIN_CYC (`PSC_MODE_WIN_MS * `PSC_CLK_MHZ * 1000)
`endif

/* rtl/psc_pkg.sv */
package psc_pkg;
  typedef enum logic [4:0] {
    PSC_MODE_STANDBY = 5'h01,
    PSC_MODE_AUTO = 5'h02,
    PSC_MODE_SEMI = 5'h04,
    PSC_MODE_MANUAL = 5'h08,
    PSC_MODE_PWRDOWN = 5'h10
  } psc_mode_t;

  typedef struct packed {
    logic endpoint;
    logic [1:0] chan_code;
    logic boot_auto;
    logic supply_dcdc;
    logic [1:0] shunt_code;
    logic [1:0] test_code;
    logic scan;
    logic [4:0] bus_address;
  } psc_strap_t;

  typedef struct packed {
    logic endpoint;
    logic boost;
    logic chan_bad;
    logic supply_dcdc;
    logic [15:0] shunt_mohm;
    logic [2:0] current_scale;
    logic functional;
    logic [4:0] bus_address;
    logic [3:0] port_groups;
  } psc_cfg_t;
endpackage : psc_pkg

/* rtl/psc_sync3.sv */
`timescale 1ns/10ps
// three-stage synchroniser; a change counts once stages two and three agree
module psc_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } psc_sync_state_t;

  psc_sync_state_t st;
  psc_sync_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st.s2[i] == st.s3[i])
      begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q_o = st.q;
endmodule : psc_sync3

/* rtl/psc_strap_loader.sv */
`timescale 1ns/10ps
`include "psc_defines.svh"
// How it works
// - architecture select low gives midspan, high gives endpoint for all channels.
// - channel code 00 is twelve standard channels, 11 four boosted; 01 and 10 are flagged.
// - boot strap low leaves ports disabled and mode at power-down after reset.
// - boot strap high sets mode to automatic and enables all ports after reset.
// - shunt code 00/01/10/11 means 0.5/1/1.5/2 ohm and sets the current scale.
// - the bus target address comes from five address straps.
// - serial data is received on its own input pin, synchronised to the clock together with serial clock.
// - serial data leaves on a separate output pin; the board joins in and out.
// - the open-drain interrupt pin is pulled low while an event is notified.
// - only test code 00 gives functional operation.
// - supply mode select left open runs the switching supply as a dc-dc controller.
// - chip reset is active low and holds all strap state at reset value.
// - mode changes are taken only within 100 ms after reset until detection starts, in stand-by, or when stand-by is requested.
module psc_strap_loader #(
  parameter int MODE_WIN_CYC = `PSC_MODE_WIN_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // configuration straps
  input wire logic architecture_select_i,
  input wire logic [1:0] channel_count_select_i,
  input wire logic boot_auto_i,
  input wire logic supply_mode_select_i,
  input wire logic [1:0] shunt_value_strap_i,
  input wire logic [1:0] test_select_i,
  input wire logic scan_strap_i,
  input wire logic [4:0] bus_address_strap_i,
  // serial pins
  input wire logic serial_clock_in_pin_i,
  input wire logic serial_data_in_pin_i,
  output logic serial_clock_o,
  output logic serial_data_o,
  output logic serial_data_out_pin_o,
  // core side of serial and interrupt
  input wire logic core_sda_low_i,
  input wire logic irq_event_i,
  output logic irq_low_out_o,
  output logic irq_low_out_oe_o,
  // operating mode requests
  input wire logic mode_req_i,
  input wire psc_pkg::psc_mode_t mode_req_val_i,
  input wire logic detect_started_i,
  // decoded outputs
  output psc_pkg::psc_cfg_t cfg_o,
  output psc_pkg::psc_mode_t mode_o,
  output logic ports_enabled_o,
  output logic mode_window_o,
  output logic cfg_valid_o
);
  localparam int CW = $clog2(MODE_WIN_CYC + 1);

  typedef struct packed {
    logic loaded;
    psc_pkg::psc_strap_t straps;
    psc_pkg::psc_cfg_t cfg;
    psc_pkg::psc_mode_t mode;
    logic ports_en;
    logic window;
    logic [CW-1:0] win_cnt;
    logic scl;
    logic sda;
    logic sda_out;
    logic irq_oe;
  } psc_state_t;

  psc_state_t st;
  psc_state_t next_st;
  logic [1:0] serial_sync;
  psc_pkg::psc_strap_t strap_now;

  function automatic logic [15:0] shunt_mohm(input logic [1:0] code);
    case (code)
      2'h0: shunt_mohm = `PSC_SHUNT_MOHM_0;
      2'h1: shunt_mohm = `PSC_SHUNT_MOHM_1;
      2'h2: shunt_mohm = `PSC_SHUNT_MOHM_2;
      default: shunt_mohm = `PSC_SHUNT_MOHM_3;
    endcase
  endfunction : shunt_mohm

  function automatic logic [2:0] shunt_scale(input logic [1:0] code);
    case (code)
      2'h0: shunt_scale = `PSC_SCALE_0;
      2'h1: shunt_scale = `PSC_SCALE_1;
      2'h2: shunt_scale = `PSC_SCALE_2;
      default: shunt_scale = `PSC_SCALE_3;
    endcase
  endfunction : shunt_scale

  // serial pins come from outside the clock domain
  psc_sync3 #(
    .W(2)
  ) u_serial_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i({serial_clock_in_pin_i, serial_data_in_pin_i}),
    .q_o(serial_sync)
  );

  // straps are static; sampled directly at the first edge after release
  always_comb
  begin
    strap_now.endpoint = architecture_select_i;
    strap_now.chan_code = channel_count_select_i;
    strap_now.boot_auto = boot_auto_i;
    strap_now.supply_dcdc = supply_mode_select_i;
    strap_now.shunt_code = shunt_value_strap_i;
    strap_now.test_code = test_select_i;
    strap_now.scan = scan_strap_i;
    strap_now.bus_address = bus_address_strap_i;
  end

  always_comb
  begin
    next_st = st;
    if (!st.loaded)
    begin
      next_st.loaded = 1'b1;
      next_st.straps = strap_now;
      next_st.cfg.endpoint = strap_now.endpoint;
      next_st.cfg.boost = (strap_now.chan_code == `PSC_CHAN_BOOST);
      next_st.cfg.chan_bad = (strap_now.chan_code != `PSC_CHAN_TWELVE) &&
        (strap_now.chan_code != `PSC_CHAN_BOOST);
      next_st.cfg.port_groups = (strap_now.chan_code == `PSC_CHAN_BOOST) ?
        4'h4 : 4'hc;
      // open pin pulls high: dc-dc controller mode
      next_st.cfg.supply_dcdc = strap_now.supply_dcdc;
      next_st.cfg.shunt_mohm = shunt_mohm(strap_now.shunt_code);
      next_st.cfg.current_scale = shunt_scale(strap_now.shunt_code);
      next_st.cfg.functional = (strap_now.test_code == `PSC_TEST_FUNC) &&
        !strap_now.scan;
      next_st.cfg.bus_address = strap_now.bus_address;
      next_st.mode = strap_now.boot_auto ? psc_pkg::PSC_MODE_AUTO :
        psc_pkg::PSC_MODE_PWRDOWN;
      next_st.ports_en = strap_now.boot_auto;
      next_st.window = 1'b1;
      next_st.win_cnt = CW'(MODE_WIN_CYC);
    end
    else
    begin
      if (st.window && (st.win_cnt == '0 || detect_started_i))
      begin
        next_st.window = 1'b0;
      end
      if (st.win_cnt != '0)
      begin
        next_st.win_cnt = st.win_cnt - CW'(1);
      end
      if (mode_req_i && (st.window && !detect_started_i ||
          st.mode == psc_pkg::PSC_MODE_STANDBY ||
          mode_req_val_i == psc_pkg::PSC_MODE_STANDBY))
      begin
        next_st.mode = mode_req_val_i;
        next_st.ports_en = (mode_req_val_i != psc_pkg::PSC_MODE_PWRDOWN) &&
          (mode_req_val_i != psc_pkg::PSC_MODE_STANDBY);
      end
    end
    next_st.scl = serial_sync[1];
    next_st.sda = serial_sync[0];
    next_st.sda_out = !core_sda_low_i;
    next_st.irq_oe = !irq_event_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.mode <= psc_pkg::PSC_MODE_PWRDOWN;
      st.sda_out <= 1'b1;
      st.irq_oe <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cfg_o = st.cfg;
  assign mode_o = st.mode;
  assign ports_enabled_o = st.ports_en;
  assign mode_window_o = st.window;
  assign cfg_valid_o = st.loaded;
  assign serial_clock_o = st.scl;
  assign serial_data_o = st.sda;
  assign serial_data_out_pin_o = st.sda_out;
  assign irq_low_out_o = 1'b0;
  assign irq_low_out_oe_o = st.irq_oe;

  chk_straps_held: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.loaded && $past(st.loaded) |-> $stable(st.cfg))
    else $error("strap config changed after load");
  chk_boot_mode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st.loaded ##1 st.loaded |-> (st.mode == psc_pkg::PSC_MODE_AUTO) == $past(boot_auto_i))
    else $error("boot mode not from strap");
  chk_ports_auto: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st.loaded ##1 st.loaded |-> st.ports_en == $past(boot_auto_i))
    else $error("ports enable not from strap");
  chk_arch_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st.loaded ##1 st.loaded |-> st.cfg.endpoint == $past(architecture_select_i))
    else $error("architecture decode wrong");
  chk_boost_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.loaded |-> st.cfg.boost == (st.straps.chan_code == 2'h3))
    else $error("channel count decode wrong");
  chk_shunt_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.loaded |-> st.cfg.shunt_mohm == 16'h01f4 + 16'(st.straps.shunt_code) * 16'h01f4)
    else $error("shunt decode wrong");
  chk_addr_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.loaded |-> st.cfg.bus_address == st.straps.bus_address)
    else $error("bus address wrong");
  chk_test_func: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.loaded && st.cfg.functional |-> st.straps.test_code == 2'h0)
    else $error("functional with reserved test code");
  chk_irq_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    irq_event_i |=> !irq_low_out_oe_o)
    else $error("interrupt not pulled low");
  chk_sda_out: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    core_sda_low_i |=> !serial_data_out_pin_o)
    else $error("data out pin not low");
  chk_mode_locked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.loaded && !st.window && st.mode != psc_pkg::PSC_MODE_STANDBY &&
    !(mode_req_i && mode_req_val_i == psc_pkg::PSC_MODE_STANDBY) |=> $stable(st.mode))
    else $error("mode changed outside window");

  cov_boot_auto: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    st.loaded && st.mode == psc_pkg::PSC_MODE_AUTO);
  cov_boost: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    st.loaded && st.cfg.boost);
  cov_window_change: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    st.window && mode_req_i);
endmodule : psc_strap_loader

/* dv/psc_board_model.sv */
`timescale 1ns/10ps
// board straps and a host sharing one wired-and sda line with the device
module psc_board_model (
  // settings asked of the board
  input wire psc_pkg::psc_strap_t want_i,
  input wire logic host_scl_i,
  input wire logic host_sda_low_i,
  input wire logic dut_sda_i,
  // pins toward the device
  output psc_pkg::psc_strap_t pins_o,
  output logic scl_pin_o,
  output logic sda_pin_o
);
  always_comb
  begin
    pins_o = want_i;
    pins_o.chan_code = {2{want_i.chan_code[1]}};
    pins_o.test_code = 2'h0;
    pins_o.scan = 1'b0;
  end
  assign scl_pin_o = host_scl_i;
  assign sda_pin_o = dut_sda_i & !host_sda_low_i;
endmodule : psc_board_model

/* dv/test_pse_strap_config_and_host_pins.sv */
`timescale 1ns/10ps
module test_pse_strap_config_and_host_pins;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  psc_pkg::psc_strap_t want = '0;
  psc_pkg::psc_strap_t pins;
  logic host_scl = 1'b1;
  logic host_sda_low = 1'b0;
  logic core_sda_low = 1'b0;
  logic irq_event = 1'b0;
  logic mode_req = 1'b0;
  logic detect_started = 1'b0;
  psc_pkg::psc_mode_t mode_req_val = psc_pkg::PSC_MODE_STANDBY;
  psc_pkg::psc_mode_t mode;
  psc_pkg::psc_mode_t exp_mode;
  psc_pkg::psc_cfg_t cfg;
  logic scl_pin, sda_pin, sclk, sdat, sda_out, irq_o, irq_oe, ports_en, win, valid;
  int fails = 0;
  int compares = 0;
  logic [31:0] seed = 32'h29db4493;
  psc_pkg::psc_mode_t seq [5] = '{psc_pkg::PSC_MODE_STANDBY, psc_pkg::PSC_MODE_SEMI,
    psc_pkg::PSC_MODE_MANUAL, psc_pkg::PSC_MODE_PWRDOWN, psc_pkg::PSC_MODE_AUTO};

  always #2 clock_i = ~clock_i;

  psc_board_model board (.want_i(want), .host_scl_i(host_scl), .host_sda_low_i(host_sda_low),
    .dut_sda_i(sda_out), .pins_o(pins), .scl_pin_o(scl_pin), .sda_pin_o(sda_pin));

  psc_strap_loader #(.MODE_WIN_CYC(50)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .architecture_select_i(pins.endpoint), .channel_count_select_i(pins.chan_code),
    .boot_auto_i(pins.boot_auto), .supply_mode_select_i(pins.supply_dcdc),
    .shunt_value_strap_i(pins.shunt_code), .test_select_i(pins.test_code),
    .scan_strap_i(pins.scan), .bus_address_strap_i(pins.bus_address),
    .serial_clock_in_pin_i(scl_pin), .serial_data_in_pin_i(sda_pin), .serial_clock_o(sclk),
    .serial_data_o(sdat), .serial_data_out_pin_o(sda_out), .core_sda_low_i(core_sda_low),
    .irq_event_i(irq_event), .irq_low_out_o(irq_o), .irq_low_out_oe_o(irq_oe),
    .mode_req_i(mode_req), .mode_req_val_i(mode_req_val), .detect_started_i(detect_started),
    .cfg_o(cfg), .mode_o(mode), .ports_enabled_o(ports_en), .mode_window_o(win),
    .cfg_valid_o(valid));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic do_reset();
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    chk("valid", 16'h0, valid);
    chk("mode", psc_pkg::PSC_MODE_PWRDOWN, mode);
    chk("sda_out", 16'h1, sda_out);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask : do_reset

  task automatic chk_cfg(input psc_pkg::psc_strap_t s);
    chk("endpoint", s.endpoint, cfg.endpoint);
    chk("boost", s.chan_code == 2'h3, cfg.boost);
    chk("chan_bad", 16'h0, cfg.chan_bad);
    chk("groups", s.chan_code == 2'h3 ? 16'h4 : 16'hc, cfg.port_groups);
    chk("shunt", 16'(500 * (s.shunt_code + 1)), cfg.shunt_mohm);
    chk("scale", s.shunt_code == 0 ? 4 : s.shunt_code == 1 ? 2 : 1, cfg.current_scale);
    chk("functional", 16'h1, cfg.functional);
    chk("address", s.bus_address, cfg.bus_address);
    chk("dcdc", s.supply_dcdc, cfg.supply_dcdc);
    chk("boot_mode", s.boot_auto ? psc_pkg::PSC_MODE_AUTO : psc_pkg::PSC_MODE_PWRDOWN,
      mode);
    chk("ports", s.boot_auto, ports_en);
    chk("valid", 16'h1, valid);
  endtask : chk_cfg

  // a refused request leaves the expected mode as it was
  task automatic mreq(input psc_pkg::psc_mode_t m, input logic open);
    if (open || exp_mode == psc_pkg::PSC_MODE_STANDBY || m == psc_pkg::PSC_MODE_STANDBY)
      exp_mode = m;
    @(posedge clock_i);
    mode_req <= 1'b1;
    mode_req_val <= m;
    @(posedge clock_i);
    mode_req <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    chk("mode", exp_mode, mode);
    chk("ports", exp_mode != psc_pkg::PSC_MODE_STANDBY
      && exp_mode != psc_pkg::PSC_MODE_PWRDOWN, ports_en);
  endtask : mreq

  initial
  begin
    repeat (20000) @(posedge clock_i);
    fails++;
    close_out();
  end

  initial
  begin
    psc_pkg::psc_strap_t s;
    logic [31:0] r;
    repeat (8)
    begin
      r = rnd();
      @(posedge clock_i);
      want <= psc_pkg::psc_strap_t'(r[14:0]);
      do_reset();
      s = pins;
      chk_cfg(s);
      @(posedge clock_i);
      want <= ~want;
      repeat (3) @(negedge clock_i);
      chk_cfg(s);
    end
    $display("test strap decode done");
    exp_mode = mode;
    chk("window", 16'h1, win);
    foreach (seq[i])
      mreq(seq[i], 1'b1);
    @(posedge clock_i);
    detect_started <= 1'b1;
    repeat (2) @(negedge clock_i);
    chk("window", 16'h0, win);
    mreq(psc_pkg::PSC_MODE_SEMI, 1'b0);
    mreq(psc_pkg::PSC_MODE_STANDBY, 1'b0);
    mreq(psc_pkg::PSC_MODE_MANUAL, 1'b0);
    mreq(psc_pkg::PSC_MODE_SEMI, 1'b0);
    @(posedge clock_i);
    detect_started <= 1'b0;
    do_reset();
    exp_mode = mode;
    repeat (55) @(negedge clock_i);
    chk("window", 16'h0, win);
    mreq(psc_pkg::PSC_MODE_MANUAL, 1'b0);
    $display("test mode window done");
    repeat (16)
    begin
      r = rnd();
      @(posedge clock_i);
      host_scl <= r[0];
      host_sda_low <= r[1];
      core_sda_low <= r[2];
      irq_event <= r[3];
      repeat (7) @(negedge clock_i);
      chk("scl", r[0], sclk);
      chk("sda_in", !r[1] && !r[2], sdat);
      chk("sda_out", !r[2], sda_out);
      chk("irq_oe", !r[3], irq_oe);
      chk("irq_level", 16'h0, irq_o);
    end
    $display("test serial and irq pins done");
    close_out();
  end
endmodule : test_pse_strap_config_and_host_pins
